// ### rtl/adcas_top.sv
// alert, busy pin, channel sequencer and daisy-chain serial port of the converter
`timescale 1ns/1ps
module adcas_top
  import adcas_pkg::*;
#(
  parameter int NUM_CH = 8
) (
  input  wire logic                            SYS_CLK_IN,
  input  wire logic                            RSTN_IN,
  input  wire logic                            SCLK_IN,
  input  wire logic                            CS_N_IN,
  input  wire logic                            CONVERSION_START_N_IN,
  input  wire logic                            SERIAL_IN_IN,
  input  wire logic [adcas_pkg::CODE_W-1:0]    CONV_CODE_IN,
  input  wire adcas_pkg::adcas_limit_s [NUM_CH-1:0] LIMITS_IN,
  output logic                                 SERIAL_OUT_OUT,
  output logic                                 SERIAL_OUT_OE_OUT,
  output logic                                 SHARED_INDICATOR_PIN_OUT,
  output logic                                 SHARED_INDICATOR_PIN_OE_OUT,
  output logic [2:0]                           CHANNEL_SEL_OUT,
  output logic                                 CONV_BUSY_OUT
);
  import adcas_pkg::*;

  initial
  begin
    if (NUM_CH < 1 || NUM_CH > MAX_CH)
      $error("channel count must lie between one and eight");
  end

  localparam int CONV_DLY = CONV_CYCLES + 1;

  function automatic logic [2:0] lowest_ch(input logic [NUM_CH-1:0] m);
    logic [2:0] r;
    r = 3'h0;
    for (int i = NUM_CH - 1; i >= 0; i--)
      if (m[i])
        r = 3'(i);
    return r;
  endfunction

  function automatic logic [2:0] next_ch(input logic [NUM_CH-1:0] m, input logic [2:0] cur);
    logic [2:0] r;
    logic       found;
    r     = lowest_ch(m);
    found = 1'b0;
    for (int i = 0; i < NUM_CH; i++)
      if (!found && m[i] && 3'(i) > cur)
      begin
        r     = 3'(i);
        found = 1'b1;
      end
    return r;
  endfunction

  // pin synchronisers: {start, data, select, clock}
  logic [3:0]          sync1_r;
  logic [3:0]          sync2_r;
  logic [3:0]          prev_r;

  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      // serial clock idles low, the other pins idle high: no false edge after reset
      sync1_r <= 4'he;
      sync2_r <= 4'he;
      prev_r  <= 4'he;
    end
    else
    begin
      sync1_r <= {CONVERSION_START_N_IN, SERIAL_IN_IN, CS_N_IN, SCLK_IN};
      sync2_r <= sync1_r;
      prev_r  <= sync2_r;
    end
  end

  logic                sclk_rise;
  logic                sclk_fall;
  logic                cs_n_s;
  logic                cs_fall;
  logic                cs_rise;
  logic                ser_in_s;
  logic                conv_fall;

  assign sclk_rise = sync2_r[0] && !prev_r[0];
  assign sclk_fall = !sync2_r[0] && prev_r[0];
  assign cs_n_s    = sync2_r[1];
  assign cs_fall   = !sync2_r[1] && prev_r[1];
  assign cs_rise   = sync2_r[1] && !prev_r[1];
  assign ser_in_s  = sync2_r[2];
  assign conv_fall = !sync2_r[3] && prev_r[3];

  // state shared between concerns
  adcas_pin_cfg_s      cfg_r;
  logic [NUM_CH-1:0]   chan_en_r;
  logic [NUM_CH-1:0]   act_mask_r;
  logic                seq_pend_r;
  logic [2:0]          cur_ch_r;
  logic [2:0]          next_ch_r;
  logic [NUM_CH-1:0]   hi_r;
  logic [NUM_CH-1:0]   lo_r;
  logic [NUM_CH-1:0]   hi_nxt;
  logic [NUM_CH-1:0]   lo_nxt;
  logic                alert_any;
  adcas_result_s       result_r;
  logic                conv_pend_r;
  logic [CMD_W-1:0]    read_data_r;
  logic                read_pend_r;
  adcas_conv_e         conv_st_r;
  logic [5:0]          conv_cnt_r;
  logic                busy_r;

  assign alert_any = |(hi_r | lo_r);

  // serial shifter: receive on rising clock, send on falling clock
  logic [CMD_W-1:0]    rx_r;
  logic [CMD_W-1:0]    tx_r;
  logic [7:0]          bit_cnt_r;
  logic                ser_out_r;
  logic                ser_out_oe_r;
  logic [CMD_W-1:0]    tx_word;
  logic                rx_msb;

  assign rx_msb = rx_r[CMD_W-1];
  // a finished conversion overrides a pending register read
  assign tx_word = (conv_pend_r || !read_pend_r) ? CMD_W'(result_r) : read_data_r;

  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      rx_r      <= '0;
      tx_r      <= '0;
      bit_cnt_r <= 8'h00;
      ser_out_r    <= 1'b0;
      ser_out_oe_r <= 1'b0;
    end
    else if (cs_fall)
    begin
      bit_cnt_r <= 8'h00;
      ser_out_r    <= tx_word[CMD_W-1];
      tx_r         <= {tx_word[CMD_W-2:0], 1'b0};
      ser_out_oe_r <= 1'b1;
    end
    else if (cs_rise)
      ser_out_oe_r <= 1'b0;
    else if (!cs_n_s)
    begin
      if (sclk_rise)
      begin
        rx_r <= {rx_r[CMD_W-2:0], ser_in_s};
        if (bit_cnt_r != 8'hff)
          bit_cnt_r <= bit_cnt_r + 8'h01;
      end
      if (sclk_fall)
      begin
        if (bit_cnt_r >= 8'(FRAME_BITS))
          ser_out_r <= rx_msb;
        else
        begin
          ser_out_r <= tx_r[CMD_W-1];
          tx_r  <= {tx_r[CMD_W-2:0], 1'b0};
        end
      end
    end
  end

  // hold the last whole command of the frame until the buffer accepts it
  logic [CMD_W-1:0]    hold_r;
  logic                push_pend_r;
  logic                fifo_in_ready;
  logic                fifo_out_valid;
  logic [CMD_W-1:0]    fifo_out_data;
  logic                exec_ready;
  logic                frame_done;

  assign frame_done = cs_rise && bit_cnt_r >= 8'(FRAME_BITS);

  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      hold_r      <= '0;
      push_pend_r <= 1'b0;
    end
    else if (frame_done)
    begin
      hold_r      <= rx_r;
      push_pend_r <= 1'b1;
    end
    else if (fifo_in_ready)
      push_pend_r <= 1'b0;
  end

  // the executor stalls while a conversion result is being judged
  assign exec_ready = (conv_st_r != CONV_DONE);

  adcas_fifo2 #(
    .W     (CMD_W),
    .DEPTH (FIFO_DEPTH)
  ) u_cmd_fifo (
    .clk_in        (SYS_CLK_IN),
    .rst_n_in      (RSTN_IN),
    .in_valid_in   (push_pend_r),
    .in_ready_out  (fifo_in_ready),
    .in_data_in    (hold_r),
    .out_valid_out (fifo_out_valid),
    .out_ready_in  (exec_ready),
    .out_data_out  (fifo_out_data)
  );

  adcas_cmd_s          cmd;
  logic                pop;
  logic                chan_wr;
  logic                soft_rst;
  logic                alert_rd;
  logic                alert_clr;
  logic [CMD_W-1:0]    reg_val;
  logic [CMD_W-1:0]    alert_word;

  assign cmd       = adcas_cmd_s'(fifo_out_data);
  assign pop       = fifo_out_valid && exec_ready;
  assign chan_wr   = pop && cmd.wr && cmd.addr == ADDR_CHAN;
  assign soft_rst  = pop && cmd.wr && cmd.addr == ADDR_CFG && cmd.data[CFG_SRST_BIT];
  assign alert_rd  = pop && !cmd.wr && cmd.addr == ADDR_ALERT;
  assign alert_clr = alert_rd || soft_rst;

  always_comb
  begin
    alert_word = '0;
    for (int i = 0; i < NUM_CH; i++)
    begin
      alert_word[2*i]   = hi_r[i];
      alert_word[2*i+1] = lo_r[i];
    end
    unique case (cmd.addr)
      ADDR_RESULT: reg_val = CMD_W'(result_r);
      ADDR_CHAN:   reg_val = CMD_W'(chan_en_r);
      ADDR_CFG:    reg_val = CMD_W'({cfg_r.sticky, cfg_r.drive_push_pull, cfg_r.busy_sel,
                                     cfg_r.pin_en, cfg_r.pol, 3'h0});
      ADDR_ALERT:  reg_val = alert_word;
      default:     reg_val = '0;
    endcase
  end

  // command execution
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      cfg_r       <= CFG_RESET;
      chan_en_r   <= NUM_CH'(CHAN_RESET);
      read_data_r <= '0;
      read_pend_r <= 1'b0;
    end
    else
    begin
      if (cs_fall)
        read_pend_r <= 1'b0;
      if (pop && cmd.wr)
      begin
        if (soft_rst)
        begin
          cfg_r     <= CFG_RESET;
          chan_en_r <= NUM_CH'(CHAN_RESET);
        end
        else if (cmd.addr == ADDR_CFG)
          cfg_r <= '{sticky:          cmd.data[CFG_STICKY_BIT],
                     drive_push_pull: cmd.data[CFG_DRIVE_BIT],
                     busy_sel:        cmd.data[CFG_BUSY_BIT],
                     pin_en:          cmd.data[CFG_PIN_EN_BIT],
                     pol:             cmd.data[CFG_POL_BIT]};
        else if (chan_wr)
          chan_en_r <= cmd.data[NUM_CH-1:0];
      end
      else if (pop)
      begin
        read_data_r <= reg_val;
        read_pend_r <= 1'b1;
      end
    end
  end

  // channel sequencer: the channel chosen now was decided one start earlier
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      act_mask_r <= NUM_CH'(CHAN_RESET);
      seq_pend_r <= 1'b0;
      cur_ch_r   <= 3'h0;
      next_ch_r  <= 3'h0;
    end
    else
    begin
      if (conv_fall && conv_st_r == CONV_IDLE)
      begin
        cur_ch_r   <= next_ch_r;
        act_mask_r <= chan_en_r;
        seq_pend_r <= 1'b0;
        if (seq_pend_r)
          next_ch_r <= lowest_ch(chan_en_r);
        else
          next_ch_r <= next_ch(act_mask_r, next_ch_r);
      end
      if (chan_wr || soft_rst)
        seq_pend_r <= 1'b1;
    end
  end

  // conversion timing
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      conv_st_r  <= CONV_IDLE;
      conv_cnt_r <= 6'h00;
      busy_r     <= 1'b0;
    end
    else
    begin
      unique case (conv_st_r)
        CONV_IDLE:
          if (conv_fall)
          begin
            conv_st_r  <= CONV_RUN;
            conv_cnt_r <= 6'(CONV_CYCLES - 1);
            busy_r     <= 1'b1;
          end
        CONV_RUN:
          if (conv_cnt_r == 6'h00)
            conv_st_r <= CONV_DONE;
          else
            conv_cnt_r <= conv_cnt_r - 6'h01;
        CONV_DONE:
        begin
          conv_st_r <= CONV_IDLE;
          busy_r    <= 1'b0;
        end
        default:
          conv_st_r <= CONV_IDLE;
      endcase
    end
  end

  // limit check of the channel just converted
  adcas_limit_s        lim;
  logic                over;
  logic                under;

  assign lim   = LIMITS_IN[cur_ch_r];
  assign over  = CONV_CODE_IN > lim.upper;
  assign under = CONV_CODE_IN < lim.lower;

  always_comb
  begin
    hi_nxt = hi_r;
    lo_nxt = lo_r;
    if (alert_clr)
    begin
      hi_nxt = '0;
      lo_nxt = '0;
    end
    if (conv_st_r == CONV_DONE)
    begin
      if (!cfg_r.sticky)
      begin
        if ({1'b0, CONV_CODE_IN} + {1'b0, lim.hyst} < {1'b0, lim.upper})
          hi_nxt[cur_ch_r] = 1'b0;
        if ({1'b0, CONV_CODE_IN} > {1'b0, lim.lower} + {1'b0, lim.hyst})
          lo_nxt[cur_ch_r] = 1'b0;
      end
      // a new violation wins over any clear in the same cycle
      if (over)
        hi_nxt[cur_ch_r] = 1'b1;
      if (under)
        lo_nxt[cur_ch_r] = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      hi_r        <= '0;
      lo_r        <= '0;
      result_r    <= '0;
      conv_pend_r <= 1'b0;
    end
    else
    begin
      hi_r <= hi_nxt;
      lo_r <= lo_nxt;
      if (conv_st_r == CONV_DONE)
      begin
        result_r    <= '{chan: cur_ch_r, alert: |(hi_nxt | lo_nxt), code: CONV_CODE_IN};
        conv_pend_r <= 1'b1;
      end
      else
      begin
        if (alert_clr)
          result_r.alert <= 1'b0;
        if (cs_fall)
          conv_pend_r <= 1'b0;
      end
    end
  end

  // shared indicator pin
  logic                pin_out_r;
  logic                pin_oe_r;
  logic                pin_active;
  logic                pin_level;

  assign pin_active = cfg_r.pin_en && (cfg_r.busy_sel ? busy_r : alert_any);
  assign pin_level  = cfg_r.pol ? pin_active : !pin_active;

  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN)
  begin
    if (!RSTN_IN)
    begin
      pin_out_r <= 1'b0;
      pin_oe_r  <= 1'b0;
    end
    else if (cfg_r.drive_push_pull)
    begin
      pin_out_r <= pin_level;
      pin_oe_r  <= 1'b1;
    end
    else
    begin
      // open drain only pulls low, so several parts can share the wire
      pin_out_r <= 1'b0;
      pin_oe_r  <= !pin_level;
    end
  end

  assign SERIAL_OUT_OUT              = ser_out_r;
  assign SERIAL_OUT_OE_OUT           = ser_out_oe_r;
  assign SHARED_INDICATOR_PIN_OUT    = pin_out_r;
  assign SHARED_INDICATOR_PIN_OE_OUT = pin_oe_r;
  assign CHANNEL_SEL_OUT             = cur_ch_r;
  assign CONV_BUSY_OUT               = busy_r;

  property p_upper_set;
    @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    (conv_st_r == CONV_DONE && over) |=> hi_r[$past(cur_ch_r)];
  endproperty
  a_upper_set: assert property (p_upper_set) else $error("upper violation not flagged");

  property p_lower_set;
    @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    (conv_st_r == CONV_DONE && under) |=> lo_r[$past(cur_ch_r)];
  endproperty
  a_lower_set: assert property (p_lower_set) else $error("lower violation not flagged");

  property p_common_bit;
    @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    (conv_st_r == CONV_DONE) |=> (result_r.alert == alert_any);
  endproperty
  a_common_bit: assert property (p_common_bit) else $error("result alert bit differs from flags");

  property p_alert_pin;
    @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    (cfg_r.pin_en && !cfg_r.busy_sel && cfg_r.drive_push_pull)
      |=> (pin_out_r == ($past(cfg_r.pol) ? $past(alert_any) : !$past(alert_any)));
  endproperty
  a_alert_pin: assert property (p_alert_pin) else $error("alert pin level wrong");

  property p_read_clear;
    @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    alert_rd |=> (!alert_any && !result_r.alert);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("alert read did not clear");

  property p_sticky_hold;
    @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    (cfg_r.sticky && !alert_clr && hi_r[cur_ch_r]) |=> hi_r[$past(cur_ch_r)];
  endproperty
  a_sticky_hold: assert property (p_sticky_hold) else $error("sticky flag cleared itself");

  property p_soft_reset;
    @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    soft_rst |=> (hi_r == '0 && lo_r == '0);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("software reset left alerts");

  property p_open_drain;
    @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    !cfg_r.drive_push_pull |=> !pin_out_r;
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open drain pin drove high");

  property p_busy_pin;
    @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    (cfg_r.pin_en && cfg_r.busy_sel && cfg_r.drive_push_pull)
      |=> (pin_out_r == ($past(cfg_r.pol) ? $past(busy_r) : !$past(busy_r)));
  endproperty
  a_busy_pin: assert property (p_busy_pin) else $error("busy pin level wrong");

  property p_conv_len;
    @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    (conv_fall && conv_st_r == CONV_IDLE) |-> ##CONV_DLY (conv_st_r == CONV_DONE);
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_pass_through;
    @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    (!cs_n_s && !cs_fall && !cs_rise && sclk_fall && bit_cnt_r >= 8'(FRAME_BITS)) |=> (ser_out_r == $past(rx_msb));
  endproperty
  a_pass_through: assert property (p_pass_through) else $error("chain data not passed");

  property p_last_cmd;
    @(posedge SYS_CLK_IN) disable iff (!RSTN_IN)
    frame_done |=> (push_pend_r && hold_r == $past(rx_r));
  endproperty
  a_last_cmd: assert property (p_last_cmd) else $error("last command not captured");
endmodule

// ### rtl/adcas_pkg.sv
// constants, types and command layout for the converter control block
package adcas_pkg;

  localparam int          MAX_CH         = 8;
  localparam int          CODE_W         = 12;
  localparam int          CMD_W          = 16;
  localparam int          FIFO_DEPTH     = 2;
  localparam int          FRAME_BITS     = 16;

  // register addresses inside the serial command
  localparam logic [4:0]  ADDR_RESULT    = 5'h00;
  localparam logic [4:0]  ADDR_CHAN      = 5'h01;
  localparam logic [4:0]  ADDR_CFG       = 5'h02;
  localparam logic [4:0]  ADDR_ALERT     = 5'h03;

  // configuration bit positions
  localparam int          CFG_POL_BIT    = 3;
  localparam int          CFG_PIN_EN_BIT = 4;
  localparam int          CFG_BUSY_BIT   = 5;
  localparam int          CFG_DRIVE_BIT  = 6;
  localparam int          CFG_STICKY_BIT = 7;
  localparam int          CFG_SRST_BIT   = 9;

  localparam logic [7:0]  CHAN_RESET     = 8'h00;

  // conversion time, rounded up to whole clocks
  localparam int          CLK_PERIOD_NS  = 25;
  localparam int          CONV_TIME_NS   = 600;
  localparam int          CONV_CYCLES    = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef struct packed {
    logic [4:0]        addr;
    logic              wr;
    logic [9:0]        data;
  } adcas_cmd_s;

  typedef struct packed {
    logic              sticky;
    logic              drive_push_pull;
    logic              busy_sel;
    logic              pin_en;
    logic              pol;
  } adcas_pin_cfg_s;

  localparam adcas_pin_cfg_s CFG_RESET = 5'h00;

  typedef struct packed {
    logic [2:0]        chan;
    logic              alert;
    logic [CODE_W-1:0] code;
  } adcas_result_s;

  typedef struct packed {
    logic [CODE_W-1:0] upper;
    logic [CODE_W-1:0] lower;
    logic [CODE_W-1:0] hyst;
  } adcas_limit_s;

  typedef enum logic [1:0] {
    CONV_IDLE = 2'b00,
    CONV_RUN  = 2'b01,
    CONV_DONE = 2'b10
  } adcas_conv_e;

endpackage

// ### rtl/adcas_fifo2.sv
// small command buffer between the serial receiver and the executor
`timescale 1ns/1ps
module adcas_fifo2 #(
  parameter int W     = 16,
  parameter int DEPTH = 2
) (
  input  wire logic         clk_in,
  input  wire logic         rst_n_in,
  input  wire logic         in_valid_in,
  output logic              in_ready_out,
  input  wire logic [W-1:0] in_data_in,
  output logic              out_valid_out,
  input  wire logic         out_ready_in,
  output logic [W-1:0]      out_data_out
);
  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  initial
  begin
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
      $error("fifo depth must be a power of two, at least two");
  end

  logic [W-1:0]  mem_r [DEPTH];
  logic [PW-1:0] wr_ptr_r;
  logic [PW-1:0] rd_ptr_r;
  logic [PW:0]   count_r;
  logic          push;
  logic          pop;

  assign in_ready_out  = (count_r != (PW+1)'(DEPTH));
  assign out_valid_out = (count_r != '0);
  assign out_data_out  = mem_r[rd_ptr_r];
  assign push          = in_valid_in && in_ready_out;
  assign pop           = out_valid_out && out_ready_in;

  always_ff @(posedge clk_in)
  begin
    if (push)
      mem_r[wr_ptr_r] <= in_data_in;
  end

  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      if (pop)
        rd_ptr_r <= rd_ptr_r + 1'b1;
      if (push && !pop)
        count_r <= count_r + 1'b1;
      else if (pop && !push)
        count_r <= count_r - 1'b1;
    end
  end
endmodule

// ### tb/adcas_master.sv
// serial master model: select, serial clock, conversion start and command data
`timescale 1ns/1ps
module adcas_master (
  input  wire logic clk_in,
  input  wire logic miso_in,
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      conv_n_out,
  output logic      mosi_out
);
  initial
  begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    conv_n_out = 1'b1;
    mosi_out = 1'b0;
  end

  // serial clock only runs inside a frame, 8 system clocks per bit
  task automatic xfer(input int n, input logic [31:0] tx, output logic [31:0] rx);
    rx = '0;
    cs_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    for (int i = n - 1; i >= 0; i--)
    begin
      sclk_out <= 1'b0;
      mosi_out <= tx[i];
      repeat (4) @(posedge clk_in);
      sclk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      rx = {rx[30:0], miso_in};
    end
    sclk_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    cs_n_out <= 1'b1;
    // released data line toggles so a stale bit is never mistaken for data
    mosi_out <= ~mosi_out;
    repeat (12) @(posedge clk_in);
  endtask

  task automatic convert();
    conv_n_out <= 1'b0;
    repeat (4) @(posedge clk_in);
    conv_n_out <= 1'b1;
  endtask
endmodule

// ### tb/tb_top.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb_top;
  import adcas_pkg::*;
  logic                      sys_clk, rstn, sclk, cs_n, conv_n, ser_in, ser_out, ser_oe, pin, pin_oe, busy;
  logic [2:0]                chan;
  logic [CODE_W-1:0]         code;
  adcas_limit_s [MAX_CH-1:0] limits;
  logic [31:0]               rx;
  logic [2:0]                seq [4] = '{3'h0, 3'h1, 3'h3, 3'h1};
  int                        fails = 0;
  int                        check_count = 0;

  adcas_top #(.NUM_CH(MAX_CH)) adcas_top_i (.SYS_CLK_IN(sys_clk), .RSTN_IN(rstn), .SCLK_IN(sclk),
    .CS_N_IN(cs_n), .CONVERSION_START_N_IN(conv_n), .SERIAL_IN_IN(ser_in), .CONV_CODE_IN(code),
    .LIMITS_IN(limits), .SERIAL_OUT_OUT(ser_out), .SERIAL_OUT_OE_OUT(ser_oe), .SHARED_INDICATOR_PIN_OUT(pin),
    .SHARED_INDICATOR_PIN_OE_OUT(pin_oe), .CHANNEL_SEL_OUT(chan), .CONV_BUSY_OUT(busy));
  adcas_master adcas_master_i (.clk_in(sys_clk), .miso_in(ser_out), .sclk_out(sclk), .cs_n_out(cs_n),
    .conv_n_out(conv_n), .mosi_out(ser_in));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [9:0] d);
    adcas_master_i.xfer(16, {16'h0000, a, 1'b1, d}, rx);
  endtask

  task automatic rd(input logic [4:0] a);
    adcas_master_i.xfer(16, {16'h0000, a, 1'b0, 10'h000}, rx);
  endtask

  task automatic conv();
    adcas_master_i.convert();
    repeat (34) @(posedge sys_clk);
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  initial
  begin
    #600us;
    fails++;
    give_verdict();
  end

  initial
  begin
    rstn = 1'b0;
    code = 12'h400;
    limits = '0;
    for (int i = 0; i < MAX_CH; i++)
      limits[i] = {12'hfff, 12'h000, 12'h000};
    repeat (3) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    check("pin oe", pin_oe, 0);
    check("serial oe", ser_oe, 0);
    check("chan", chan, 0);
    wr(ADDR_CFG, 10'h078);
    adcas_master_i.convert();
    repeat (2) @(posedge sys_clk);
    check("busy pin", {busy, pin, pin_oe}, 3'h7);
    repeat (32) @(posedge sys_clk);
    check("idle pin high pol", pin, 0);
    wr(ADDR_CFG, 10'h070);
    check("idle pin low pol", pin, 1);
    wr(ADDR_CHAN, 10'h00a);
    for (int i = 0; i < 4; i++)
    begin
      conv();
      check("seq chan", chan, seq[i]);
    end
    limits[1] <= {12'h800, 12'h100, 12'h010};
    limits[3] <= {12'h800, 12'h100, 12'h010};
    wr(ADDR_CFG, 10'h0d8);
    code <= 12'hf00;
    conv();
    check("alert pin", pin, 1);
    code <= 12'h400;
    conv();
    conv();
    check("sticky chan", chan, 3);
    check("sticky pin", pin, 1);
    rd(ADDR_ALERT);
    check("result word", rx[15:0], 16'h7400);
    rd(ADDR_RESULT);
    check("alert reg", rx[15:0], 16'h0040);
    check("cleared pin", pin, 0);
    wr(ADDR_CFG, 10'h058);
    code <= 12'hf00;
    conv();
    check("auto alert", pin, 1);
    code <= 12'h400;
    conv();
    conv();
    check("auto clear", pin, 0);
    conv();
    code <= 12'hf00;
    conv();
    check("alert again", pin, 1);
    code <= 12'h050;
    conv();
    rd(ADDR_ALERT);
    check("low result word", rx[15:0], 16'h7050);
    rd(ADDR_RESULT);
    check("low and high flags", rx[15:0], 16'h0084);
    code <= 12'hf00;
    conv();
    check("alert before srst", pin, 1);
    wr(ADDR_CFG, 10'h200);
    wr(ADDR_CFG, 10'h058);
    check("srst pin", pin, 0);
    wr(ADDR_CFG, 10'h018);
    check("open drain", {pin, pin_oe}, 2'h1);
    adcas_master_i.xfer(32, {16'h0cff, 16'h0800}, rx);
    check("pass through", rx[15:0], 16'h0cff);
    rd(ADDR_RESULT);
    check("last cmd only", rx[15:0], 16'h0000);
    give_verdict();
  end
endmodule
